// File: ctu_top.sv
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ctu_top
  import ctu_pkg::*;
#(
  parameter int PULSE_LEN = PULSE_CYCLES
)(
  // clock and reset
  input  wire logic              I_CLK,
  input  wire logic              I_RSTN,
  // register port
  input  wire logic [ADDR_W-1:0] I_ADDR,
  input  wire logic [15:0]       I_WDATA,
  input  wire logic              I_WR,
  input  wire logic              I_RD,
  output logic      [15:0]       O_RDATA,
  // device state
  input  wire logic              I_IDLE,
  // edge sources
  input  wire logic              I_EDGE_PIN_ONE,
  input  wire logic              I_EDGE_PIN_TWO,
  input  wire logic              I_OUTPUT_COMPARE_ONE,
  input  wire logic              I_TIMER_ONE,
  // comparator two, high when the delay capacitor is above the reference
  input  wire logic              I_COMP_TWO_OUT,
  // analog controls
  output logic                   O_UNIT_ACTIVE,
  output logic                   O_ROUTE_TO_COMP_B,
  output logic                   O_CHARGE,
  output logic                   O_SOURCE_GROUND,
  output logic                   O_SOURCE_ON,
  output logic      [5:0]        O_CURRENT_TRIM,
  output logic      [1:0]        O_CURRENT_RANGE,
  // timing outputs
  output logic                   O_TRIGGER_OUT,
  output logic                   O_PULSE_OUT
);
  localparam int CW = $clog2(PULSE_LEN + 1);
  localparam logic [CW-1:0] PULSE_LAST = CW'(PULSE_LEN - 1);

  logic [15:0]    ctl_q;
  logic [15:2]    cfg_q;
  logic [1:0]     seen_q;
  logic [15:0]    cur_q;
  logic [15:0]    rdata_q;
  logic           trig_q;
  logic [CW-1:0]  cnt_q;
  ctu_state_e     state_q;
  ctu_state_e     state_d;
  logic           hit1;
  logic           hit2;
  logic           active;
  logic           dly_mode;
  logic           e1_set;
  logic           e2_set;
  logic           wr_ctl;
  logic           wr_cur;

  function automatic logic [15:0] reg_read(input logic [ADDR_W-1:0] a,
                                           input logic [15:0] c,
                                           input logic [15:0] i);
    case (a)
      ADDR_CTL: reg_read = c & CTL_MASK;
      ADDR_CUR: reg_read = i & CUR_MASK;
      default:  reg_read = 16'h0000;
    endcase
  endfunction

  assign wr_ctl = I_WR && (I_ADDR == ADDR_CTL);
  assign wr_cur = I_WR && (I_ADDR == ADDR_CUR);

  // unit runs only when on and not halted by Idle
  assign active = ctl_q[B_UNIT_ON] & ~(ctl_q[B_HALT_IDLE] & I_IDLE);
  assign dly_mode = active & ctl_q[B_DLY_GEN];

  ctu_edge_det u_edge1 (
    .i_clk       (I_CLK),
    .i_rstn      (I_RSTN),
    .i_pin_one   (I_EDGE_PIN_ONE),
    .i_pin_two   (I_EDGE_PIN_TWO),
    .i_oc_one    (I_OUTPUT_COMPARE_ONE),
    .i_timer_one (I_TIMER_ONE),
    .i_sel       (ctl_q[B_E1_SRC_LO+:2]),
    .i_rising    (ctl_q[B_E1_POL]),
    .o_hit       (hit1)
  );

  ctu_edge_det u_edge2 (
    .i_clk       (I_CLK),
    .i_rstn      (I_RSTN),
    .i_pin_one   (I_EDGE_PIN_ONE),
    .i_pin_two   (I_EDGE_PIN_TWO),
    .i_oc_one    (I_OUTPUT_COMPARE_ONE),
    .i_timer_one (I_TIMER_ONE),
    .i_sel       (ctl_q[B_E2_SRC_LO+:2]),
    .i_rising    (ctl_q[B_E2_POL]),
    .o_hit       (hit2)
  );

  // qualification of the two edge events
  assign e1_set = active & ctl_q[B_EDGE_PASS] & hit1;
  assign e2_set = active & ctl_q[B_EDGE_PASS] & hit2
                & (~ctl_q[B_EDGE_ORDER] | ctl_q[B_E1_SEEN]);

  // configuration part of the control register
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      cfg_q <= CTL_RESET[15:2];
    end else if (wr_ctl) begin
      cfg_q <= I_WDATA[15:2] & CTL_MASK[15:2];
    end
  end

  // seen flags: a hardware set wins over a software clear in the same cycle
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      seen_q[B_E1_SEEN] <= 1'b0;
      seen_q[B_E2_SEEN] <= 1'b0;
    end else begin
      if (e1_set) begin
        seen_q[B_E1_SEEN] <= 1'b1;
      end else if (wr_ctl) begin
        seen_q[B_E1_SEEN] <= I_WDATA[B_E1_SEEN];
      end
      if (e2_set) begin
        seen_q[B_E2_SEEN] <= 1'b1;
      end else if (wr_ctl) begin
        seen_q[B_E2_SEEN] <= I_WDATA[B_E2_SEEN];
      end
    end
  end

  // current control register, low byte not implemented
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      cur_q <= CUR_RESET;
    end else if (wr_cur) begin
      cur_q <= I_WDATA & CUR_MASK;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rdata_q <= 16'h0000;
    end else if (I_RD) begin
      rdata_q <= reg_read(I_ADDR, ctl_q, cur_q);
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  // delay generation sequence
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (e1_set) begin
          state_d = ST_CHARGE;
        end
      end
      ST_CHARGE: begin
        if (I_COMP_TWO_OUT) begin
          state_d = ST_PULSE;
        end
      end
      ST_PULSE: begin
        if (cnt_q == PULSE_LAST) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // leaving the mode or switching off abandons any sequence in flight
    if (!dly_mode) begin
      state_d = ST_IDLE;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      cnt_q <= '0;
    end else if (state_q == ST_PULSE && state_d == ST_PULSE) begin
      cnt_q <= cnt_q + CW'(1);
    end else begin
      cnt_q <= '0;
    end
  end

  // trigger output marks each accepted second edge
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= e2_set & ctl_q[B_TRIG_EN];
    end
  end

  assign ctl_q             = {cfg_q, seen_q};
  assign O_RDATA           = rdata_q;
  assign O_UNIT_ACTIVE     = active;
  assign O_ROUTE_TO_COMP_B = dly_mode;
  assign O_CHARGE          = (state_q == ST_CHARGE);
  assign O_PULSE_OUT       = (state_q == ST_PULSE);
  assign O_SOURCE_GROUND   = ctl_q[B_SRC_GND];
  assign O_CURRENT_TRIM    = cur_q[B_TRIM_LO+:6];
  assign O_CURRENT_RANGE   = cur_q[B_RANGE_LO+:2];
  assign O_SOURCE_ON       = active & (cur_q[B_RANGE_LO+:2] != RANGE_OFF);
  assign O_TRIGGER_OUT     = trig_q;

  sequence s_armed;
    state_q == ST_IDLE && dly_mode && e1_set;
  endsequence

  sequence s_trip;
    O_CHARGE && I_COMP_TWO_OUT && dly_mode;
  endsequence

  AST_ROUTE_ON_WRITE: assert property (
    @(posedge I_CLK) disable iff (!I_RSTN)
    wr_ctl |=> O_ROUTE_TO_COMP_B == ($past(I_WDATA[B_DLY_GEN]) && $past(I_WDATA[B_UNIT_ON])
                                     && !(ctl_q[B_HALT_IDLE] && I_IDLE))
  ) else $error("routing to comparator input B wrong after write");

  AST_CHARGE_START: assert property (
    @(posedge I_CLK) disable iff (!I_RSTN)
    s_armed |=> O_CHARGE
  ) else $error("charging did not start on qualified edge");

  AST_PULSE_ON_TRIP: assert property (
    @(posedge I_CLK) disable iff (!I_RSTN)
    s_trip ##1 dly_mode |-> O_PULSE_OUT && !O_CHARGE
  ) else $error("no pulse after comparator trip");

  AST_OFF_NO_CHARGE: assert property (
    @(posedge I_CLK) disable iff (!I_RSTN)
    !ctl_q[B_UNIT_ON] |=> !O_CHARGE && !O_PULSE_OUT
  ) else $error("unit acts while switched off");

  AST_IDLE_HALT: assert property (
    @(posedge I_CLK) disable iff (!I_RSTN)
    ctl_q[B_HALT_IDLE] && I_IDLE |=> !O_CHARGE && !O_PULSE_OUT && !O_TRIGGER_OUT
  ) else $error("unit acts in Idle while halt is set");

  AST_BLOCKED: assert property (
    @(posedge I_CLK) disable iff (!I_RSTN)
    !ctl_q[B_EDGE_PASS] && !wr_ctl |=> $stable(ctl_q[1:0])
  ) else $error("seen flag changed while edges blocked");

  AST_ORDER: assert property (
    @(posedge I_CLK) disable iff (!I_RSTN)
    ctl_q[B_EDGE_ORDER] && !ctl_q[B_E1_SEEN] && !ctl_q[B_E2_SEEN] && !wr_ctl
    |=> !ctl_q[B_E2_SEEN]
  ) else $error("second edge accepted before first");

  AST_SEEN_HOLDS: assert property (
    @(posedge I_CLK) disable iff (!I_RSTN)
    ctl_q[B_E1_SEEN] && !wr_ctl |=> ctl_q[B_E1_SEEN]
  ) else $error("first seen flag dropped without a write");

  AST_CUR_WRITE: assert property (
    @(posedge I_CLK) disable iff (!I_RSTN)
    wr_cur |=> O_CURRENT_TRIM == $past(I_WDATA[15:10])
           && O_CURRENT_RANGE == $past(I_WDATA[9:8])
  ) else $error("current control write not taken");

  AST_READ_ZEROS: assert property (
    @(posedge I_CLK) disable iff (!I_RSTN)
    I_RD && I_ADDR == ADDR_CUR |=> O_RDATA[7:0] == 8'h00
  ) else $error("unimplemented current control bits read nonzero");

  AST_TRIGGER: assert property (
    @(posedge I_CLK) disable iff (!I_RSTN)
    O_TRIGGER_OUT |-> $past(ctl_q[B_TRIG_EN]) && $past(active) && ctl_q[B_E2_SEEN]
  ) else $error("trigger without enabled second edge");

  AST_TRIG_DISABLED: assert property (
    @(posedge I_CLK) disable iff (!I_RSTN)
    !ctl_q[B_TRIG_EN] |=> !O_TRIGGER_OUT
  ) else $error("trigger output while disabled");

  AST_RDATA_ONE_CYCLE: assert property (
    @(posedge I_CLK) disable iff (!I_RSTN)
    !I_RD |=> O_RDATA == 16'h0000
  ) else $error("read data stands outside its cycle");

  AST_CTL_GAP_ZERO: assert property (
    @(posedge I_CLK) disable iff (!I_RSTN)
    I_RD && I_ADDR == ADDR_CTL |=> !O_RDATA[14]
  ) else $error("unimplemented control bit reads nonzero");

  AST_UNMAPPED_READ: assert property (
    @(posedge I_CLK) disable iff (!I_RSTN)
    I_RD && I_ADDR != ADDR_CTL && I_ADDR != ADDR_CUR |=> O_RDATA == 16'h0000
  ) else $error("unmapped address reads nonzero");

  AST_RANGE_OFF: assert property (
    @(posedge I_CLK) disable iff (!I_RSTN)
    wr_cur && I_WDATA[B_RANGE_LO+:2] == RANGE_OFF |=> !O_SOURCE_ON
  ) else $error("current source on with range off");

  AST_GROUND_WRITE: assert property (
    @(posedge I_CLK) disable iff (!I_RSTN)
    wr_ctl |=> O_SOURCE_GROUND == $past(I_WDATA[B_SRC_GND])
  ) else $error("source ground does not follow its bit");

  AST_E1_SET: assert property (
    @(posedge I_CLK) disable iff (!I_RSTN)
    e1_set |=> ctl_q[B_E1_SEEN]
  ) else $error("qualified first edge not recorded");

  AST_E2_SET: assert property (
    @(posedge I_CLK) disable iff (!I_RSTN)
    e2_set |=> ctl_q[B_E2_SEEN]
  ) else $error("qualified second edge not recorded");

  AST_NO_MODE_QUIET: assert property (
    @(posedge I_CLK) disable iff (!I_RSTN)
    !dly_mode |=> !O_CHARGE && !O_PULSE_OUT
  ) else $error("charge or pulse outside delay mode");

  AST_CHARGE_HOLDS: assert property (
    @(posedge I_CLK) disable iff (!I_RSTN)
    O_CHARGE && !I_COMP_TWO_OUT && dly_mode |=> O_CHARGE
  ) else $error("charging stopped before the trip");

  sequence s_pulse_last;
    O_PULSE_OUT && cnt_q == PULSE_LAST;
  endsequence

  AST_PULSE_ENDS: assert property (
    @(posedge I_CLK) disable iff (!I_RSTN)
    s_pulse_last |=> !O_PULSE_OUT
  ) else $error("pulse longer than its length");

  AST_PULSE_HOLDS: assert property (
    @(posedge I_CLK) disable iff (!I_RSTN)
    O_PULSE_OUT && cnt_q != PULSE_LAST && dly_mode |=> O_PULSE_OUT
  ) else $error("pulse shorter than its length");
endmodule
`default_nettype wire

// File: ctu_pkg.sv
// How it works
// - delay-generation enable, bit 12, routes the current source to comparator two input B.
// - in delay-generation mode a qualified first-edge event starts capacitor charging.
// - in delay-generation mode a comparator trip drives a pulse on the pulse output.
// - unit-on bit 15 switches the unit on at 1, off at 0; source-ground, trim and range outputs follow their bits either way.
// - halt-when-idle bit 13 stops the unit in Idle mode; 0 keeps it running.
// - edge-pass bit 11 passes edge events at 1, blocks all at 0.
// - edge-order bit 10 accepts a second edge only after a first edge.
// - source-ground bit 9 grounds the current source output at 1.
// - trigger-output bit 8 enables the trigger output at 1.
// - second-edge polarity bit 7 selects rising at 1, falling at 0.
// - second-edge source bits 6-5: 11 pin one, 10 pin two, 01 compare, 00 timer.
// - first-edge polarity bit 4 selects rising at 1, falling at 0.
// - first-edge source bits 3-2 use the same source encoding.
// - second-edge seen bit 1 reads 1 once a second edge has occurred.
// - first-edge seen bit 0 reads 1 once a first edge has occurred.
// - current trim bits 15-10 are a signed trim, zero is nominal.
// - current range bits 9-8: 00 off, 01 base, 10 ten, 11 hundred times.
// - unimplemented bits ignore writes and read zero.
package ctu_pkg;
  localparam int          ADDR_W        = 4;
  localparam logic [3:0]  ADDR_CTL      = 4'h0;
  localparam logic [3:0]  ADDR_CUR      = 4'h1;
  localparam logic [15:0] CTL_RESET     = 16'h0000;
  localparam logic [15:0] CUR_RESET     = 16'h0000;
  localparam logic [15:0] CTL_MASK      = 16'hBFFF;
  localparam logic [15:0] CUR_MASK      = 16'hFF00;
  localparam int          B_UNIT_ON     = 15;
  localparam int          B_HALT_IDLE   = 13;
  localparam int          B_DLY_GEN     = 12;
  localparam int          B_EDGE_PASS   = 11;
  localparam int          B_EDGE_ORDER  = 10;
  localparam int          B_SRC_GND     = 9;
  localparam int          B_TRIG_EN     = 8;
  localparam int          B_E2_POL      = 7;
  localparam int          B_E2_SRC_LO   = 5;
  localparam int          B_E1_POL      = 4;
  localparam int          B_E1_SRC_LO   = 2;
  localparam int          B_E2_SEEN     = 1;
  localparam int          B_E1_SEEN     = 0;
  localparam int          B_TRIM_LO     = 10;
  localparam int          B_RANGE_LO    = 8;
  localparam logic [1:0]  SRC_PIN_ONE   = 2'h3;
  localparam logic [1:0]  SRC_PIN_TWO   = 2'h2;
  localparam logic [1:0]  SRC_OC_ONE    = 2'h1;
  localparam logic [1:0]  SRC_TIMER_ONE = 2'h0;
  localparam logic [1:0]  RANGE_OFF     = 2'h0;
  localparam int          CLK_PERIOD_NS = 40;
  localparam int          PULSE_TIME_NS = 160;
  localparam int          PULSE_CYCLES  = (PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_CHARGE = 2'b01,
    ST_PULSE  = 2'b10
  } ctu_state_e;
endpackage

// File: ctu_edge_det.sv
`timescale 1ns/1ps
`default_nettype none
module ctu_edge_det
  import ctu_pkg::*;
(
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  // edge sources
  input  wire logic       i_pin_one,
  input  wire logic       i_pin_two,
  input  wire logic       i_oc_one,
  input  wire logic       i_timer_one,
  // selection
  input  wire logic [1:0] i_sel,
  input  wire logic       i_rising,
  // result
  output logic            o_hit
);
  logic cur;
  logic prev_q;

  // changing the source can look like an edge; software should set up with edges blocked
  always_comb begin
    case (i_sel)
      SRC_PIN_ONE: cur = i_pin_one;
      SRC_PIN_TWO: cur = i_pin_two;
      SRC_OC_ONE:  cur = i_oc_one;
      default:     cur = i_timer_one;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= cur;
    end
  end

  assign o_hit = i_rising ? (cur & ~prev_q) : (~cur & prev_q);
endmodule
`default_nettype wire

// File: ctu_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module ctu_far_side (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  // from the unit
  input  wire logic       i_charge,
  input  wire logic       i_ground,
  // to the unit, index equals the source select code
  output logic      [3:0] o_src,
  output logic            o_comp
);
  int unsigned trip_cycles;
  int unsigned level_q;
  initial begin
    o_src       = 4'h0;
    trip_cycles = 3;
  end
  // capacitor drains as soon as charging stops or the source is grounded
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn)
      level_q <= 0;
    else if (i_charge && !i_ground)
      level_q <= level_q + 1;
    else
      level_q <= 0;
  end
  assign o_comp = (level_q >= trip_cycles);
  task automatic drive_src(input int idx, input logic val);
    @(posedge i_clk);
    o_src[idx] <= val;
  endtask
endmodule
`default_nettype wire

// File: edge_timed_pulse_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module edge_timed_pulse_control_bench;
  import ctu_pkg::*;
  localparam int PLEN = 3;
  logic        clk, rstn, wr_s, rd_s, idle, comp, act, route, charge, gnd, son, trig, pulse;
  logic [3:0]  addr, src;
  logic [15:0] wdata, rdata;
  logic [5:0]  trim;
  logic [1:0]  rng;
  int          err_total, n_tests, mdl_ctl, mdl_cur, n;

  ctu_top #(.PULSE_LEN(PLEN)) DUT (.I_CLK(clk), .I_RSTN(rstn), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata), .I_IDLE(idle),
    .I_EDGE_PIN_ONE(src[3]), .I_EDGE_PIN_TWO(src[2]), .I_OUTPUT_COMPARE_ONE(src[1]),
    .I_TIMER_ONE(src[0]), .I_COMP_TWO_OUT(comp), .O_UNIT_ACTIVE(act),
    .O_ROUTE_TO_COMP_B(route), .O_CHARGE(charge), .O_SOURCE_GROUND(gnd),
    .O_SOURCE_ON(son), .O_CURRENT_TRIM(trim), .O_CURRENT_RANGE(rng),
    .O_TRIGGER_OUT(trig), .O_PULSE_OUT(pulse));
  ctu_far_side far (.i_clk(clk), .i_rstn(rstn), .i_charge(charge), .i_ground(gnd),
    .o_src(src), .o_comp(comp));

  always #20 clk = ~clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    if (a == ADDR_CTL) mdl_ctl = d & CTL_MASK;
    if (a == ADDR_CUR) mdl_cur = d & CUR_MASK;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input int exp);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk(rdata, exp[15:0]);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #(40 * 20000);
    err_total++;
    tally_and_finish();
  end

  initial begin
    clk = 0; rstn = 0; wr_s = 0; rd_s = 0; addr = 0; wdata = 0; idle = 0;
    err_total = 0; n_tests = 0; mdl_ctl = 0; mdl_cur = 0;
    void'($urandom(82655));
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    rd(ADDR_CTL, 0);
    rd(ADDR_CUR, 0);
    chk({act, route, charge, gnd, son, trig, pulse}, 0);
    wr(ADDR_CTL, 16'h7FFF);
    rd(ADDR_CTL, mdl_ctl);
    @(posedge clk);
    #1 chk(rdata, 0);
    wr(ADDR_CTL, 16'h0000);
    n = $urandom;
    wr(ADDR_CUR, n[15:0]);
    rd(ADDR_CUR, mdl_cur);
    chk(16'(trim), 16'(mdl_cur[15:10]));
    chk(16'(rng), 16'(mdl_cur[9:8]));
    wr(4'h7, 16'hFFFF);
    rd(4'h7, 0);
    rd(ADDR_CUR, mdl_cur);
    wr(ADDR_CUR, 16'h0100);
    wr(ADDR_CTL, 16'h8200);
    chk({act, son, gnd}, 16'h0007);
    wr(ADDR_CUR, 16'h0000);
    chk(son, 0);
    @(posedge clk);
    idle <= 1'b1;
    wr(ADDR_CTL, 16'hA000);
    chk(act, 0);
    wr(ADDR_CTL, 16'h8000);
    chk(act, 1);
    @(posedge clk);
    idle <= 1'b0;
    // all sources share one level so that a select change cannot fake an edge
    for (int s = 0; s < 4; s++) begin
      for (int p = 0; p < 2; p++) begin
        for (int k = 0; k < 4; k++) far.drive_src(k, p[0]);
        wr(ADDR_CTL, 16'(32'h8800 | (p << 7) | (s << 5) | (p << 4) | (s << 2)));
        far.drive_src(s, !p[0]);
        rd(ADDR_CTL, mdl_ctl);
        far.drive_src(s, p[0]);
        @(posedge clk);
        #1 chk({trig, charge}, 0);
        rd(ADDR_CTL, mdl_ctl | 3);
      end
    end
    far.drive_src(3, 1'b0);
    wr(ADDR_CTL, 16'h801C);
    far.drive_src(3, 1'b1);
    rd(ADDR_CTL, mdl_ctl);
    far.drive_src(3, 1'b0);
    wr(ADDR_CTL, 16'h081C);
    far.drive_src(3, 1'b1);
    rd(ADDR_CTL, mdl_ctl);
    far.drive_src(3, 1'b0);
    far.drive_src(2, 1'b0);
    wr(ADDR_CTL, 16'h8CDC);
    far.drive_src(2, 1'b1);
    rd(ADDR_CTL, mdl_ctl);
    far.drive_src(3, 1'b1);
    rd(ADDR_CTL, mdl_ctl | 1);
    far.drive_src(2, 1'b0);
    far.drive_src(2, 1'b1);
    rd(ADDR_CTL, mdl_ctl | 3);
    wr(ADDR_CTL, 16'h8CDC);
    rd(ADDR_CTL, mdl_ctl);
    wr(ADDR_CTL, 16'h8800);
    chk(route, 0);
    // comparator trips after 1 to 20 charge cycles, drawn at random
    for (int t = 0; t < 4; t++) begin
      far.trip_cycles = 1 + $urandom % 20;
      far.drive_src(3, 1'b0);
      wr(ADDR_CTL, 16'h99FC);
      chk(route, 1);
      far.drive_src(3, 1'b1);
      @(posedge clk);
      #1 chk({charge, trig}, 16'h0003);
      @(posedge clk);
      #1 chk(trig, 0);
      n = 0;
      while (pulse !== 1'b1 && n < 100) begin
        @(posedge clk);
        #1 n++;
      end
      chk({pulse, charge}, 16'h0002);
      n = 0;
      while (pulse === 1'b1 && n < 20) begin
        n++;
        @(posedge clk);
        #1;
      end
      chk(16'(n), 16'(PLEN));
    end
    // halting in Idle abandons a charge in flight
    far.trip_cycles = 50;
    far.drive_src(3, 1'b0);
    wr(ADDR_CTL, 16'hB9FC);
    far.drive_src(3, 1'b1);
    @(posedge clk);
    idle <= 1'b1;
    #1 chk(charge, 1);
    @(posedge clk);
    #1 chk({charge, route, act}, 0);
    @(posedge clk);
    idle <= 1'b0;
    tally_and_finish();
  end
endmodule
`default_nettype wire
